/* File: src/audio_cfg_pkg.sv */
// Package for the audio path configuration register bank.
// Assumes a serial front end that delivers whole 16-bit words per load command.
`default_nettype none
package audio_cfg_pkg;
  localparam int CFG_WIDTH = 16;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Word select codes from the serial command decoder
  localparam logic SEL_LOW = 1'b0;
  localparam logic SEL_HIGH = 1'b1;
  // Low register field positions
  localparam int VOL_OFF_BIT = 0;
  localparam int SPK_MODE_LSB = 1;
  localparam int OUT_SRC_LSB = 3;
  localparam int AOUT_OFF_BIT = 5;
  localparam int AOUT_SRC_LSB = 6;
  localparam int IN_SRC_BIT = 9;
  localparam int AUX_OFF_BIT = 10;
  localparam int AUX_GAIN_LSB = 11;
  localparam int AIN_OFF_BIT = 13;
  localparam int AIN_GAIN_LSB = 14;
  // High register field positions
  localparam int AGC_OFF_BIT = 0;
  localparam int LPF_OFF_BIT = 1;
  localparam int RATE_LSB = 2;
  localparam int FILT_SRC_BIT = 4;
  localparam int MIX2_MODE_LSB = 5;
  localparam int MIX1_MODE_LSB = 7;
  localparam int MIX1_SRC_LSB = 9;
  localparam int ATTEN_LSB = 11;
  localparam int ATTEN_SRC_LSB = 14;
  // Encodings named by behaviour
  localparam logic [2:0] AOUT_SRC_FEEDTHROUGH = 3'h0;
  localparam logic [1:0] AIN_GAIN_ATTEN9 = 2'h1;
  localparam logic [1:0] OUT_SRC_ANALOG_IN = 2'h1;
  localparam logic [1:0] SPK_HIGH_AUX_OFF = 2'h1;
  localparam logic IN_SRC_AGC = 1'b0;
  localparam logic [1:0] RATE_6K4 = 2'h1;
  localparam logic [1:0] RATE_5K3 = 2'h2;
  localparam logic FILT_SRC_MIXER1 = 1'b0;
  localparam logic FILT_SRC_ARRAY = 1'b1;
  localparam logic [1:0] MIX1_SRC_ANALOG_IN = 2'h0;
  localparam logic [1:0] MIX1_MUX_ONLY = 2'h1;
  localparam logic [1:0] MIX1_INPUT_ONLY = 2'h2;
  localparam logic [1:0] MIX_POWER_DOWN = 2'h3;
  localparam logic [1:0] MIX2_LPF_ONLY = 2'h2;

  typedef struct packed {
    logic [1:0] analog_in_gain_sel;
    logic analog_in_amp_off;
    logic [1:0] aux_in_gain_sel;
    logic aux_in_amp_off;
    logic input_source_sel;
    logic [2:0] analog_out_source_sel;
    logic analog_out_amp_off;
    logic [1:0] output_source_sel;
    logic [1:0] speaker_aux_amp_mode;
    logic volume_stage_off;
  } low_fields_type;

  typedef struct packed {
    logic [1:0] attenuation_source_sel;
    logic [2:0] attenuation_level;
    logic [1:0] mixer_one_source_sel;
    logic [1:0] mixer_one_mode;
    logic [1:0] mixer_two_mode;
    logic filter_source_sel;
    logic [1:0] sample_rate_sel;
    logic lowpass_stage_off;
    logic gain_control_amp_off;
  } high_fields_type;
endpackage
`default_nettype wire

/* File: src/audio_path_config_registers.sv */
// Audio path configuration register bank: holding register, commit, field decode.
// Assumes the serial decoder gives the word and a one-cycle load pulse at slave select rise.
// Summary of operation
// - Bits 8:6 of low register pick analog output source; zero is feedthrough.
// - Low bit 5 powers analog output amplifier down when one.
// - Low bits 15:14 set analog input gain; 01 is 9 dB attenuation.
// - Low bit 13 powers analog input amplifier down when one.
// - Low bits 4:3 pick output mux; 01 routes analog input to speaker.
// - Low bits 2:1 set speaker/aux amps; 01 speaker high gain, aux off.
// - Low bit 0 turns volume stage off when one.
// - Low bit 10 powers aux input amplifier down when one.
// - Low bit 9 steers input source mux; zero picks gain control amp.
// - Low bits 12:11 select aux input amplifier gain.
// - High bit 1 powers low-pass filter down when one.
// - High bit 0 powers gain control amplifier down when one.
// - High bits 3:2 select sample rate; 01 is 6.4 kHz, 10 is 5.3 kHz.
// - High bit 4 picks filter source: mixer one or storage array.
// - High bits 10:9 pick mixer one source; zero is analog input.
// - High bits 8:7 set mixer one mode; 11 powers it down.
// - High bits 6:5 set mixer two mode; 10 low-pass only, 11 off.
// - High bits 13:11 hold volume attenuation level.
// - High bits 15:14 select volume source mux.
// - Both registers take effect together at the high register's load end.
// - Low register writes wait in a holding register until high load.
// - Writes accepted while powered down; outputs show only after power up.
`default_nettype none
module audio_path_config_registers #(
  parameter int WIDTH = audio_cfg_pkg::CFG_WIDTH
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Word load from serial decoder, pulse at slave select rise
  input wire logic i_load,
  input wire logic i_load_sel,
  input wire logic [WIDTH-1:0] i_load_data,
  // Chip power-up control bit
  input wire logic i_chip_power_up_bit,
  // Active settings as whole words
  output logic [WIDTH-1:0] o_active_low,
  output logic [WIDTH-1:0] o_active_high,
  // Decoded path controls
  output audio_cfg_pkg::low_fields_type o_low_fields,
  output audio_cfg_pkg::high_fields_type o_high_fields,
  // Convenience status decodes
  output logic o_mixer_one_off,
  output logic o_mixer_two_off,
  output logic o_feedthrough_path
);
  logic [WIDTH-1:0] hold_low_r;
  logic [WIDTH-1:0] commit_low_r;
  logic [WIDTH-1:0] commit_high_r;
  logic commit_load;
  logic hold_load;

  function automatic logic mix_off(input logic [1:0] mode);
    mix_off = (mode == audio_cfg_pkg::MIX_POWER_DOWN);
  endfunction

  assign hold_load = i_load && (i_load_sel == audio_cfg_pkg::SEL_LOW);
  assign commit_load = i_load && (i_load_sel == audio_cfg_pkg::SEL_HIGH);

  // Low word parks here so half-written settings never reach the analog path
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      hold_low_r <= audio_cfg_pkg::CFG_RESET;
    end else if (hold_load) begin
      hold_low_r <= i_load_data;
    end
  end

  // Both words commit on the same edge; host ordering keeps low word current
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      commit_low_r <= audio_cfg_pkg::CFG_RESET;
      commit_high_r <= audio_cfg_pkg::CFG_RESET;
    end else if (commit_load) begin
      commit_low_r <= hold_low_r;
      commit_high_r <= i_load_data;
    end
  end

  // Writes always land; outputs gated to reset value while chip is down
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_active_low <= audio_cfg_pkg::CFG_RESET;
      o_active_high <= audio_cfg_pkg::CFG_RESET;
    end else if (i_chip_power_up_bit) begin
      o_active_low <= commit_low_r;
      o_active_high <= commit_high_r;
    end else begin
      o_active_low <= audio_cfg_pkg::CFG_RESET;
      o_active_high <= audio_cfg_pkg::CFG_RESET;
    end
  end

  // Field order in the structs matches bit order D15..D0
  assign o_low_fields =
    audio_cfg_pkg::low_fields_type'(
      o_active_low);
  assign o_high_fields =
    audio_cfg_pkg::high_fields_type'(o_active_high);

  assign o_mixer_one_off = mix_off(o_high_fields.mixer_one_mode);
  assign o_mixer_two_off = mix_off(o_high_fields.mixer_two_mode);
  assign o_feedthrough_path =
    (o_low_fields.analog_out_source_sel == audio_cfg_pkg::AOUT_SRC_FEEDTHROUGH);

  // Assertions
  // Multi-step behaviours are built from these sequences
  sequence commit_then_up_s;
    commit_load ##1 (i_chip_power_up_bit && !commit_load);
  endsequence

  sequence steady_up_s;
    (i_chip_power_up_bit && !commit_load) ##1 i_chip_power_up_bit;
  endsequence

  // The host leaves one idle edge between its two loads
  sequence low_gap_commit_s;
    hold_load ##2 commit_load;
  endsequence

  sequence down_then_up_s;
    !i_chip_power_up_bit ##1 (i_chip_power_up_bit && !commit_load);
  endsequence

  // Holding and commit path
  hold_stable_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    !hold_load |=> hold_low_r == $past(hold_low_r))
    else $error("holding word changed without low load");

  hold_take_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    hold_load |=> hold_low_r == $past(i_load_data))
    else $error("low load not taken whole");

  low_isolated_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    hold_load && !commit_load |=> commit_low_r == $past(commit_low_r))
    else $error("low load reached active settings");

  hold_keep_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    commit_load |=> hold_low_r == $past(hold_low_r))
    else $error("holding word lost at commit");

  commit_both_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    commit_load |=> commit_low_r == $past(hold_low_r)
      && commit_high_r == $past(i_load_data))
    else $error("commit did not take both words");

  commit_idle_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    !commit_load |=> commit_low_r == $past(commit_low_r)
      && commit_high_r == $past(commit_high_r))
    else $error("committed words changed without high load");

  pair_commit_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    low_gap_commit_s |=> commit_low_r == $past(i_load_data, 3))
    else $error("low word of a pair not committed");

  // Power gating
  power_gate_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    !i_chip_power_up_bit |=> o_active_low == audio_cfg_pkg::CFG_RESET
      && o_active_high == audio_cfg_pkg::CFG_RESET)
    else $error("settings visible while powered down");

  down_store_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    commit_load && !i_chip_power_up_bit |=> commit_high_r == $past(i_load_data))
    else $error("load lost while powered down");

  power_show_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    steady_up_s |=> o_active_high == $past(commit_high_r)
      && o_active_low == $past(commit_low_r))
    else $error("settings not shown while powered up");

  wake_show_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    down_then_up_s |=> o_active_low == $past(commit_low_r))
    else $error("stored settings not shown after power up");

  end_to_end_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    commit_then_up_s |=> o_active_high == $past(i_load_data, 2))
    else $error("high word not applied two cycles after load");

  reset_clear_a: assert property (
    @(posedge i_ref_clk)
    i_reset |=> hold_low_r == audio_cfg_pkg::CFG_RESET
      && commit_high_r == audio_cfg_pkg::CFG_RESET)
    else $error("reset did not clear the words");

  // Field placement; guards the struct order against the position constants
  feedthrough_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_feedthrough_path == (o_active_low[audio_cfg_pkg::AOUT_SRC_LSB +:
      $bits(o_low_fields.analog_out_source_sel)] == audio_cfg_pkg::AOUT_SRC_FEEDTHROUGH))
    else $error("feedthrough decode wrong");

  aout_src_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_low_fields.analog_out_source_sel
      == o_active_low[audio_cfg_pkg::AOUT_SRC_LSB +: $bits(o_low_fields.analog_out_source_sel)])
    else $error("analog output source field misplaced");

  aout_bit_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_low_fields.analog_out_amp_off == o_active_low[audio_cfg_pkg::AOUT_OFF_BIT])
    else $error("analog output power bit misplaced");

  ain_gain_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_low_fields.analog_in_gain_sel
      == o_active_low[audio_cfg_pkg::AIN_GAIN_LSB +: $bits(o_low_fields.analog_in_gain_sel)])
    else $error("analog input gain field misplaced");

  ain_off_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_low_fields.analog_in_amp_off == o_active_low[audio_cfg_pkg::AIN_OFF_BIT])
    else $error("analog input power bit misplaced");

  out_src_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_low_fields.output_source_sel
      == o_active_low[audio_cfg_pkg::OUT_SRC_LSB +: $bits(o_low_fields.output_source_sel)])
    else $error("output source field misplaced");

  spk_mode_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_low_fields.speaker_aux_amp_mode
      == o_active_low[audio_cfg_pkg::SPK_MODE_LSB +: $bits(o_low_fields.speaker_aux_amp_mode)])
    else $error("speaker mode field misplaced");

  vol_off_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_low_fields.volume_stage_off == o_active_low[audio_cfg_pkg::VOL_OFF_BIT])
    else $error("volume power bit misplaced");

  aux_off_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_low_fields.aux_in_amp_off == o_active_low[audio_cfg_pkg::AUX_OFF_BIT])
    else $error("aux input power bit misplaced");

  in_src_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_low_fields.input_source_sel == o_active_low[audio_cfg_pkg::IN_SRC_BIT])
    else $error("input source bit misplaced");

  aux_gain_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_low_fields.aux_in_gain_sel
      == o_active_low[audio_cfg_pkg::AUX_GAIN_LSB +: $bits(o_low_fields.aux_in_gain_sel)])
    else $error("aux gain field misplaced");

  lpf_off_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_high_fields.lowpass_stage_off == o_active_high[audio_cfg_pkg::LPF_OFF_BIT])
    else $error("low-pass power bit misplaced");

  agc_off_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_high_fields.gain_control_amp_off == o_active_high[audio_cfg_pkg::AGC_OFF_BIT])
    else $error("gain control power bit misplaced");

  rate_field_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_high_fields.sample_rate_sel
      == o_active_high[audio_cfg_pkg::RATE_LSB +: $bits(o_high_fields.sample_rate_sel)])
    else $error("rate field misplaced");

  filt_src_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_high_fields.filter_source_sel == o_active_high[audio_cfg_pkg::FILT_SRC_BIT])
    else $error("filter source bit misplaced");

  mix1_src_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_high_fields.mixer_one_source_sel
      == o_active_high[audio_cfg_pkg::MIX1_SRC_LSB +: $bits(o_high_fields.mixer_one_source_sel)])
    else $error("mixer one source field misplaced");

  mix1_mode_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_high_fields.mixer_one_mode
      == o_active_high[audio_cfg_pkg::MIX1_MODE_LSB +: $bits(o_high_fields.mixer_one_mode)])
    else $error("mixer one mode field misplaced");

  mix2_mode_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_high_fields.mixer_two_mode
      == o_active_high[audio_cfg_pkg::MIX2_MODE_LSB +: $bits(o_high_fields.mixer_two_mode)])
    else $error("mixer two mode field misplaced");

  atten_level_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_high_fields.attenuation_level
      == o_active_high[audio_cfg_pkg::ATTEN_LSB +: $bits(o_high_fields.attenuation_level)])
    else $error("attenuation level field misplaced");

  atten_src_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_high_fields.attenuation_source_sel == o_active_high[audio_cfg_pkg::ATTEN_SRC_LSB
      +: $bits(o_high_fields.attenuation_source_sel)])
    else $error("attenuation source field misplaced");

  mixer_off_a: assert property (
    @(posedge i_ref_clk) disable iff (i_reset)
    o_mixer_one_off == (o_active_high[audio_cfg_pkg::MIX1_MODE_LSB +: $bits(o_high_fields
      .mixer_one_mode)] == audio_cfg_pkg::MIX_POWER_DOWN) && o_mixer_two_off == (o_active_high
      [audio_cfg_pkg::MIX2_MODE_LSB +: $bits(o_high_fields.mixer_two_mode)]
      == audio_cfg_pkg::MIX_POWER_DOWN))
    else $error("mixer power-down decode wrong");
endmodule
`default_nettype wire

/* File: verification/host_model.sv */
// Host model for the register bank: sends whole words as load pulses.
// Assumes each pulse stands for one finished load at slave select rise.
`default_nettype none
module host_model (
  // Clock
  input wire logic i_ref_clk,
  // Load toward the register bank
  output logic o_load,
  output logic o_load_sel,
  output logic [15:0] o_load_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_load = 1'b0;
    o_load_sel = 1'b0;
    o_load_data = 16'h0000;
  end
  // One whole 16-bit word per load; idle data shows the inverse, never a stale copy
  task automatic word(input logic sel, input logic [15:0] data);
    @(posedge i_ref_clk);
    #1;
    o_load = 1'b1;
    o_load_sel = sel;
    o_load_data = data;
    @(posedge i_ref_clk);
    #1;
    o_load = 1'b0;
    o_load_data = ~data;
  endtask
  // Low word always goes first, and a high load always follows it
  task automatic pair(input logic [15:0] low, input logic [15:0] high);
    word(audio_cfg_pkg::SEL_LOW, low);
    word(audio_cfg_pkg::SEL_HIGH, high);
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_audio_path_config_registers.sv */
// Self-checking bench for the audio path configuration register bank.
// Assumes outputs settle two edges after the high word's load edge.
`default_nettype none
module tb_audio_path_config_registers;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic hi_only; logic [15:0] low; logic [15:0] high;} row_type;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pwr = 1'b1;
  logic load;
  logic sel;
  logic [15:0] data;
  logic [15:0] act_low;
  logic [15:0] act_high;
  audio_cfg_pkg::low_fields_type low_f;
  audio_cfg_pkg::high_fields_type high_f;
  logic mix1_off;
  logic mix2_off;
  logic feedthrough_path;
  int err_count = 0;
  int num_checks = 0;
  row_type rows [4] = '{'{1'b0, 16'h440B, 16'h01E3}, '{1'b1, 16'h440B, 16'h00C5},
                        '{1'b0, 16'h2421, 16'h0148}, '{1'b0, 16'h2422, 16'h59D1}};
  always #2.5 clk = ~clk;
  host_model host (.i_ref_clk(clk), .o_load(load), .o_load_sel(sel), .o_load_data(data));
  audio_path_config_registers dut (.i_ref_clk(clk), .i_reset(rst), .i_load(load),
    .i_load_sel(sel), .i_load_data(data), .i_chip_power_up_bit(pwr),
    .o_active_low(act_low), .o_active_high(act_high), .o_low_fields(low_f),
    .o_high_fields(high_f), .o_mixer_one_off(mix1_off), .o_mixer_two_off(mix2_off),
    .o_feedthrough_path(feedthrough_path));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Full comparison of every output against one expected word pair
  task automatic check_all(input logic [15:0] low, input logic [15:0] high);
    check(act_low, low);
    check(act_high, high);
    check(low_f, low);
    check({14'h0000, low_f.speaker_aux_amp_mode}, {14'h0000, low[2:1]});
    check({15'h0000, low_f.volume_stage_off}, {15'h0000, low[0]});
    check({15'h0000, low_f.aux_in_amp_off}, {15'h0000, low[10]});
    check({15'h0000, low_f.input_source_sel}, {15'h0000, low[9]});
    check({14'h0000, low_f.aux_in_gain_sel}, {14'h0000, low[12:11]});
    check(high_f, high);
    check({14'h0000, high_f.mixer_one_mode}, {14'h0000, high[8:7]});
    check({14'h0000, high_f.mixer_two_mode}, {14'h0000, high[6:5]});
    check({13'h0000, high_f.attenuation_level}, {13'h0000, high[13:11]});
    check({14'h0000, high_f.attenuation_source_sel}, {14'h0000, high[15:14]});
    check({15'h0000, feedthrough_path}, {15'h0000, low[8:6] == 3'h0});
    check({15'h0000, mix1_off}, {15'h0000, high[8:7] == 2'h3});
    check({15'h0000, mix2_off}, {15'h0000, high[6:5] == 2'h3});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
  initial begin
    settle(5);
    rst = 1'b0;
    check_all(16'h0000, 16'h0000);
    foreach (rows[i]) begin
      if (rows[i].hi_only) begin
        host.word(audio_cfg_pkg::SEL_HIGH, rows[i].high);
      end else begin
        host.pair(rows[i].low, rows[i].high);
      end
      settle(2);
      check_all(rows[i].low, rows[i].high);
    end
    // Low word alone must wait in the holding register
    host.word(audio_cfg_pkg::SEL_LOW, 16'hFFFF);
    settle(3);
    check_all(16'h2422, 16'h59D1);
    host.word(audio_cfg_pkg::SEL_HIGH, 16'hFFFF);
    settle(2);
    check_all(16'hFFFF, 16'hFFFF);
    // Loads taken while powered down show only after power up
    pwr = 1'b0;
    host.pair(16'h440B, 16'h01E3);
    settle(2);
    check_all(16'h0000, 16'h0000);
    pwr = 1'b1;
    settle(2);
    check_all(16'h440B, 16'h01E3);
    rst = 1'b1;
    settle(2);
    rst = 1'b0;
    check_all(16'h0000, 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
